/* File: rtl/sms_pkg.sv */
package sms_pkg;
  localparam int RMS_W    = 8;
  localparam int CHANNELS = 16;
  typedef logic [RMS_W-1:0] sms_rms_t;

  // qualification thresholds in volts rms, line cut-off in volts ac
  localparam sms_rms_t ACTIVE_VRMS   = 8'h46; // 70
  localparam sms_rms_t INACTIVE_VRMS = 8'h32; // 50
  localparam sms_rms_t LINE_OFF_VAC  = 8'h50; // 80

  // timing in ms, cycle counts derived from the 100 MHz clock
  localparam int CLK_HZ          = 100_000_000;
  localparam int CYC_PER_MS      = CLK_HZ / 1000;
  localparam int FLASH2_HALF_MS  = 250;  // 2 Hz
  localparam int FLASH4_HALF_MS  = 125;  // 4 Hz
  localparam int BLINK_PERIOD_MS = 2000; // once every 2 s
  localparam int BLINK_ON_MS     = 250;
  localparam int SAMPLE_MS       = 50;
  localparam int SEQ_WINDOW_MS   = 30000;
  localparam int FLASH2_HALF_CYC  = FLASH2_HALF_MS * CYC_PER_MS;
  localparam int FLASH4_HALF_CYC  = FLASH4_HALF_MS * CYC_PER_MS;
  localparam int BLINK_PERIOD_CYC = BLINK_PERIOD_MS * CYC_PER_MS;
  localparam int BLINK_ON_CYC     = BLINK_ON_MS * CYC_PER_MS;
  localparam int SAMPLE_CYC       = SAMPLE_MS * CYC_PER_MS;
  localparam int SEQ_DEPTH        = SEQ_WINDOW_MS / SAMPLE_MS;
  localparam int CNT_W            = 28;

  // register map, byte addresses
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] STATUS_OFS  = 8'h04;
  localparam logic [7:0] CFGLOG_OFS  = 8'h08;
  localparam logic [7:0] COUNTS_OFS  = 8'h0c;
  localparam logic [7:0] SEQIDX_OFS  = 8'h10;
  localparam logic [7:0] SEQLO_OFS   = 8'h14;
  localparam logic [7:0] SEQHI_OFS   = 8'h18;
  localparam logic [31:0] CTRL_RST   = 32'h0000_5955;
  // ctrl fields
  localparam int CTRL_WDLVL_LSB = 0;
  localparam int CTRL_BROWN_LSB = 8;

  // sticky fault vector positions
  localparam int F_DC   = 0;
  localparam int F_WD   = 1;
  localparam int F_CONF = 2;
  localparam int F_DIAG = 3;
  localparam int F_RF   = 4;
  localparam int F_N    = 5;

  // configuration switches as read from the board
  typedef struct packed {
    logic [119:0] permissive;
    logic [15:0]  yellow_disable;
    logic [15:0]  dual_sequence;
    logic [8:0]   options;   // bit0 preempt_one_invert
    logic [3:0]   watchdog;  // bit0 controller_timeout_enable
  } sms_cfg_s;
  localparam int CFG_W = $bits(sms_cfg_s);
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hffff;

  typedef struct packed {
    logic line_power_lamp;
    logic dc_supply_fault_lamp;
    logic controller_timeout_lamp;
    logic conflict_lamp;
    logic diagnostic_lamp;
    logic red_fail_lamp;
  } sms_lamps_s;

  // one history sample: red, yellow, green, red enable, both preempts
  localparam int SEQ_W = 3 * CHANNELS + 3;
endpackage

/* File: rtl/sms_status_logic.sv */
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module sms_status_logic #(
  parameter int FLASH2_HALF  = sms_pkg::FLASH2_HALF_CYC,
  parameter int FLASH4_HALF  = sms_pkg::FLASH4_HALF_CYC,
  parameter int BLINK_PERIOD = sms_pkg::BLINK_PERIOD_CYC,
  parameter int BLINK_ON     = sms_pkg::BLINK_ON_CYC,
  parameter int SAMPLE       = sms_pkg::SAMPLE_CYC,
  parameter int SEQ_DEPTH    = sms_pkg::SEQ_DEPTH
) (
  input  wire logic                              core_clk_i,
  input  wire logic                              sys_rst_i,
  input  wire sms_pkg::sms_rms_t [15:0]          red_rms_i,
  input  wire sms_pkg::sms_rms_t                 red_enable_rms_i,
  input  wire sms_pkg::sms_rms_t                 preempt_one_rms_i,
  input  wire sms_pkg::sms_rms_t                 preempt_two_rms_i,
  input  wire sms_pkg::sms_rms_t                 line_rms_i,
  input  wire logic [15:0]                       yellow_on_i,
  input  wire logic [15:0]                       green_on_i,
  input  wire logic                              min_flash_i,
  input  wire logic                              red_fail_detect_i,
  input  wire logic                              dc_fault_i,
  input  wire logic                              ctl_wd_fault_i,
  input  wire logic                              conflict_fault_i,
  input  wire logic                              int_wd_fault_i,
  input  wire logic                              mem_fault_i,
  input  wire logic                              psu_fault_i,
  input  wire logic                              external_flash_input_i,
  input  wire logic                              reset_button_i,
  input  wire logic                              ext_reset_i,
  input  wire logic                              red_cable_present_i,
  input  wire sms_pkg::sms_cfg_s                 config_i,
  input  wire logic [7:0]                        paddr_i,
  input  wire logic                              psel_i,
  input  wire logic                              penable_i,
  input  wire logic                              pwrite_i,
  input  wire logic [31:0]                       pwdata_i,
  output logic [31:0]                            prdata_o,
  output logic                                   pready_o,
  output logic                                   pslverr_o,
  output sms_pkg::sms_lamps_s                    lamps_o,
  output logic [15:0]                            red_led_o,
  output logic [15:0]                            yellow_led_o,
  output logic [15:0]                            green_led_o,
  output logic                                   red_fail_mon_en_o,
  output logic                                   dual_mon_en_o,
  output logic                                   seq_mon_en_o
);
  import sms_pkg::*;

  localparam int PW = $clog2(SEQ_DEPTH);

  // refuse blink and sample counts the counters cannot hold
  if (FLASH2_HALF < 1 || FLASH4_HALF < 1 || SAMPLE < 1 || BLINK_ON < 1 ||
      BLINK_PERIOD <= BLINK_ON || BLINK_PERIOD >= (1 << CNT_W) ||
      SAMPLE >= (1 << CNT_W) || SEQ_DEPTH < 2) begin : g_bad
    $error("sms_status_logic: unsupported timing parameters");
  end

  // hysteresis: hold previous sense inside the 50..70 band
  function automatic logic qualify(input sms_rms_t lvl, input logic prev);
    if (lvl > ACTIVE_VRMS) begin
      return 1'b1;
    end else if (lvl < INACTIVE_VRMS) begin
      return 1'b0;
    end
    return prev;
  endfunction

  // crc over the whole configuration word, msb first
  function automatic logic [15:0] cfg_crc(input sms_cfg_s c);
    logic [15:0]    crc;
    logic [CFG_W-1:0] bits;
    crc  = CRC_INIT;
    bits = c;
    for (int k = CFG_W - 1; k >= 0; k--) begin
      crc = (crc[15] ^ bits[k]) ? ((crc << 1) ^ CRC_POLY) : (crc << 1);
    end
    return crc;
  endfunction

  // pins from the cabinet are asynchronous; two stages before use
  localparam int PIN_N = 10;
  logic [PIN_N-1:0] pin_meta_reg;
  logic [PIN_N-1:0] pin_sync_reg;
  sms_cfg_s         cfg_meta_reg;
  sms_cfg_s         cfg_sync_reg;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      cfg_meta_reg <= '0;
      cfg_sync_reg <= '0;
    end else begin
      pin_meta_reg <= {red_cable_present_i, ext_reset_i, reset_button_i,
                       external_flash_input_i, psu_fault_i, mem_fault_i,
                       int_wd_fault_i, conflict_fault_i, ctl_wd_fault_i, dc_fault_i};
      pin_sync_reg <= pin_meta_reg;
      cfg_meta_reg <= config_i;
      cfg_sync_reg <= cfg_meta_reg;
    end
  end
  logic dc_s, wdf_s, conf_s, diag_s, ext_flash_s, rst_btn_s, cable_s;
  assign dc_s        = pin_sync_reg[0];
  assign wdf_s       = pin_sync_reg[1];
  assign conf_s      = pin_sync_reg[2];
  assign diag_s      = pin_sync_reg[3] | pin_sync_reg[4] | pin_sync_reg[5];
  assign ext_flash_s = pin_sync_reg[6];
  assign rst_btn_s   = pin_sync_reg[7] | pin_sync_reg[8];
  assign cable_s     = pin_sync_reg[9];

  // qualified red channel sense
  logic [15:0] red_q_reg;
  for (genvar i = 0; i < CHANNELS; i++) begin : g_red
    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        red_q_reg[i] <= 1'b0;
      end else begin
        red_q_reg[i] <= qualify(red_rms_i[i], red_q_reg[i]);
      end
    end
  end

  // control inputs share the same thresholds
  logic red_en_q_reg, pre1_raw_reg, pre2_q_reg;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      red_en_q_reg <= 1'b0;
      pre1_raw_reg <= 1'b0;
      pre2_q_reg   <= 1'b0;
    end else begin
      red_en_q_reg <= qualify(red_enable_rms_i, red_en_q_reg);
      pre1_raw_reg <= qualify(preempt_one_rms_i, pre1_raw_reg);
      pre2_q_reg   <= qualify(preempt_two_rms_i, pre2_q_reg);
    end
  end

  // inverting after hysteresis swaps which threshold means active
  logic preempt_one_invert, pre1_act, pre_any, red_fn_ok;
  assign preempt_one_invert = cfg_sync_reg.options[0];
  assign pre1_act  = pre1_raw_reg ^ preempt_one_invert;
  assign pre_any   = pre1_act | pre2_q_reg;
  assign red_fn_ok = cable_s & red_en_q_reg;

  // monitoring enables; no cable means plain conflict monitoring only
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      red_fail_mon_en_o <= 1'b0;
      dual_mon_en_o     <= 1'b0;
      seq_mon_en_o      <= 1'b0;
    end else begin
      red_fail_mon_en_o <= red_fn_ok & ~pre_any;
      dual_mon_en_o     <= red_fn_ok;
      seq_mon_en_o      <= red_fn_ok & ~ext_flash_s;
    end
  end

  // flash generators: exact half periods, free running
  logic [CNT_W-1:0] f2_cnt_reg, f4_cnt_reg, blink_cnt_reg;
  logic             f2_reg, f4_reg;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      f2_cnt_reg <= '0;
      f2_reg     <= 1'b0;
    end else if (f2_cnt_reg == CNT_W'(FLASH2_HALF - 1)) begin
      f2_cnt_reg <= '0;
      f2_reg     <= ~f2_reg;
    end else begin
      f2_cnt_reg <= f2_cnt_reg + 1'b1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      f4_cnt_reg <= '0;
      f4_reg     <= 1'b0;
    end else if (f4_cnt_reg == CNT_W'(FLASH4_HALF - 1)) begin
      f4_cnt_reg <= '0;
      f4_reg     <= ~f4_reg;
    end else begin
      f4_cnt_reg <= f4_cnt_reg + 1'b1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || blink_cnt_reg == CNT_W'(BLINK_PERIOD - 1)) begin
      blink_cnt_reg <= '0;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 1'b1;
    end
  end
  logic blink;
  assign blink = blink_cnt_reg < CNT_W'(BLINK_ON);

  // one-shot reset request: a stuck switch cannot keep resetting
  logic rst_prev_reg, rst_req;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rst_prev_reg <= 1'b0;
    end else begin
      rst_prev_reg <= rst_btn_s;
    end
  end
  assign rst_req = rst_btn_s & ~rst_prev_reg;

  // sticky fault causes; a new fault wins over a reset in the same cycle
  logic [F_N-1:0] fault_now, fault_vec_reg;
  logic           fault_latched;
  assign fault_now = {red_fail_detect_i & red_fail_mon_en_o, diag_s, conf_s, wdf_s, dc_s};
  assign fault_latched = |fault_vec_reg;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      fault_vec_reg <= '0;
    end else if (rst_req) begin
      fault_vec_reg <= fault_now;
    end else begin
      fault_vec_reg <= fault_vec_reg | fault_now;
    end
  end

  // reset log: counts resets taken while a fault was latched
  logic [15:0] reset_log_cnt_reg;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      reset_log_cnt_reg <= '0;
    end else if (rst_req && fault_latched) begin
      reset_log_cnt_reg <= reset_log_cnt_reg + 1'b1;
    end
  end

  // control register, written over apb
  logic [31:0] ctrl_reg;
  sms_rms_t    brownout_lvl, wd_disable_lvl;
  assign wd_disable_lvl = ctrl_reg[CTRL_WDLVL_LSB +: RMS_W];
  assign brownout_lvl   = ctrl_reg[CTRL_BROWN_LSB +: RMS_W];

  // front panel lamps
  logic controller_timeout_enable, line_low;
  assign controller_timeout_enable = cfg_sync_reg.watchdog[0];
  assign line_low  = line_rms_i < brownout_lvl;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      lamps_o <= '0;
    end else begin
      if (line_rms_i < LINE_OFF_VAC) begin
        lamps_o.line_power_lamp <= 1'b0;
      end else if (line_low) begin
        lamps_o.line_power_lamp <= f2_reg;
      end else if (min_flash_i) begin
        lamps_o.line_power_lamp <= f4_reg;
      end else begin
        lamps_o.line_power_lamp <= 1'b1;
      end
      lamps_o.dc_supply_fault_lamp <= fault_vec_reg[F_DC];
      if (fault_vec_reg[F_WD]) begin
        lamps_o.controller_timeout_lamp <= 1'b1;
      end else begin
        lamps_o.controller_timeout_lamp <= blink & (~controller_timeout_enable |
                                           (line_rms_i < wd_disable_lvl));
      end
      lamps_o.conflict_lamp   <= fault_vec_reg[F_CONF];
      lamps_o.diagnostic_lamp <= fault_vec_reg[F_DIAG];
      if (fault_vec_reg[F_RF]) begin
        lamps_o.red_fail_lamp <= 1'b1;
      end else begin
        lamps_o.red_fail_lamp <= blink & (~red_en_q_reg | pre_any | ext_flash_s);
      end
    end
  end

  // per-channel indicators; red shows only with the red cable in
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      red_led_o    <= '0;
      yellow_led_o <= '0;
      green_led_o  <= '0;
    end else begin
      red_led_o    <= red_q_reg & {CHANNELS{cable_s}};
      yellow_led_o <= yellow_on_i;
      green_led_o  <= green_on_i;
    end
  end

  // sample tick shared by history and config compare
  logic [CNT_W-1:0] smp_cnt_reg;
  logic             tick;
  assign tick = smp_cnt_reg == CNT_W'(SAMPLE - 1);
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || tick) begin
      smp_cnt_reg <= '0;
    end else begin
      smp_cnt_reg <= smp_cnt_reg + 1'b1;
    end
  end

  // history ring; frozen while a fault is latched so the lead-up survives
  logic [SEQ_W-1:0] seq_mem [SEQ_DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wr_ptr_reg <= '0;
    end else if (tick && !fault_latched) begin
      wr_ptr_reg <= (wr_ptr_reg == PW'(SEQ_DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (tick && !fault_latched) begin
      seq_mem[wr_ptr_reg] <= {pre2_q_reg, pre1_act, red_en_q_reg,
                              green_on_i, yellow_on_i, red_q_reg};
    end
  end

  // config log: compare each tick, record crc and changed groups
  logic [15:0]   cfg_crc_reg, cfg_log_cnt_reg;
  logic [4:0]    cfg_changed_reg, cfg_diff;
  sms_cfg_s      cfg_last_reg;
  assign cfg_diff = {cfg_sync_reg.permissive     != cfg_last_reg.permissive,
                     cfg_sync_reg.yellow_disable != cfg_last_reg.yellow_disable,
                     cfg_sync_reg.dual_sequence  != cfg_last_reg.dual_sequence,
                     cfg_sync_reg.options        != cfg_last_reg.options,
                     cfg_sync_reg.watchdog       != cfg_last_reg.watchdog};
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cfg_last_reg    <= '0;
      cfg_crc_reg     <= '0;
      cfg_changed_reg <= '0;
      cfg_log_cnt_reg <= '0;
    end else if (tick && cfg_diff != '0) begin
      cfg_last_reg    <= cfg_sync_reg;
      cfg_crc_reg     <= cfg_crc(cfg_sync_reg);
      cfg_changed_reg <= cfg_diff;
      cfg_log_cnt_reg <= cfg_log_cnt_reg + 1'b1;
    end
  end

  // apb slave: decode in setup, answer in first access cycle
  logic [PW-1:0]    seq_idx_reg;
  logic [PW:0]      rd_sum;
  logic [PW-1:0]    rd_pos;
  logic [SEQ_W-1:0] seq_word;
  logic             setup, mapped;
  assign setup  = psel_i & ~penable_i;
  assign mapped = paddr_i inside {CTRL_OFS, STATUS_OFS, CFGLOG_OFS, COUNTS_OFS,
                                  SEQIDX_OFS, SEQLO_OFS, SEQHI_OFS};
  // index 0 is the newest sample
  assign rd_sum   = {1'b0, wr_ptr_reg} + (PW + 1)'(SEQ_DEPTH - 1) - {1'b0, seq_idx_reg};
  assign rd_pos   = (rd_sum >= (PW + 1)'(SEQ_DEPTH)) ? PW'(rd_sum - (PW + 1)'(SEQ_DEPTH))
                                                     : rd_sum[PW-1:0];
  assign seq_word = seq_mem[rd_pos];
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      prdata_o  <= '0;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup & ~mapped;
      prdata_o  <= '0;
      if (setup && !pwrite_i) begin
        case (paddr_i)
          CTRL_OFS:   prdata_o <= ctrl_reg;
          STATUS_OFS: prdata_o <= {4'h0, fault_vec_reg[F_N-1:0], cable_s, seq_mon_en_o,
                                   dual_mon_en_o, red_fail_mon_en_o, pre2_q_reg, pre1_act,
                                   red_en_q_reg, red_q_reg};
          CFGLOG_OFS: prdata_o <= {11'h000, cfg_changed_reg, cfg_crc_reg};
          COUNTS_OFS: prdata_o <= {reset_log_cnt_reg, cfg_log_cnt_reg};
          SEQIDX_OFS: prdata_o <= 32'(seq_idx_reg);
          SEQLO_OFS:  prdata_o <= seq_word[31:0];
          SEQHI_OFS:  prdata_o <= 32'(seq_word[SEQ_W-1:32]);
          default:    prdata_o <= '0;
        endcase
      end
    end
  end
  // writes take effect at the access edge; index saturates at depth - 1
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ctrl_reg    <= CTRL_RST;
      seq_idx_reg <= '0;
    end else if (psel_i && penable_i && pready_o && pwrite_i) begin
      if (paddr_i == CTRL_OFS) begin
        ctrl_reg <= {16'h0000, pwdata_i[15:0]};
      end
      if (paddr_i == SEQIDX_OFS) begin
        seq_idx_reg <= (pwdata_i >= 32'(SEQ_DEPTH)) ? PW'(SEQ_DEPTH - 1) : pwdata_i[PW-1:0];
      end
    end
  end

  a_red_active: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    red_rms_i[0] > ACTIVE_VRMS |=> red_q_reg[0]) else $error("red not active above 70");
  a_red_idle: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    red_rms_i[3] < INACTIVE_VRMS |=> !red_q_reg[3]) else $error("red active below 50");
  a_enable_gate: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !red_en_q_reg |=> !dual_mon_en_o && !seq_mon_en_o && !red_fail_mon_en_o)
    else $error("monitoring enabled without red enable");
  a_preempt_rf: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    pre_any && red_fn_ok |=> !red_fail_mon_en_o && dual_mon_en_o)
    else $error("preemption gating wrong");
  a_line_off: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    line_rms_i < LINE_OFF_VAC |=> !lamps_o.line_power_lamp) else $error("line lamp lit below 80");
  a_dc_lamp: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $rose(lamps_o.dc_supply_fault_lamp) |-> $past(fault_vec_reg[F_DC]))
    else $error("dc lamp without dc fault");
  a_wd_steady: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    fault_vec_reg[F_WD] ##1 fault_vec_reg[F_WD] |-> lamps_o.controller_timeout_lamp)
    else $error("timeout lamp not steady");
  a_reset_log: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    rst_req && fault_latched |=> reset_log_cnt_reg == $past(reset_log_cnt_reg) + 16'h0001)
    else $error("reset log not advanced");
  a_seq_freeze: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    fault_latched |=> wr_ptr_reg == $past(wr_ptr_reg)) else $error("history moved in fault");
  a_cfg_log: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    tick && cfg_diff != '0 |=> cfg_changed_reg != '0 && cfg_last_reg == $past(cfg_sync_reg))
    else $error("config change not logged");
endmodule

/* File: sim/signal_monitor_status_logic_tb.sv */
`timescale 1ns/100ps
module signal_monitor_status_logic_tb;
  import sms_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, mf = 0, inv = 0, xf = 0;
  logic btn = 0, cab = 1, rfd = 0, xr = 0, pready_o, pslverr_o;
  logic [5:0] flt = 0;
  logic [15:0] red = 0, yel = 0, grn = 0, rl, yl, gl;
  logic [2:0] ctl = 0, mon, mx;
  logic [7:0] paddr = 0, line = 8'h78;
  logic [31:0] pwdata = 0, prdata_o, rd;
  sms_rms_t [15:0] rr;
  sms_rms_t ren, p1, p2, lr;
  sms_cfg_s cfg;
  sms_lamps_s lamps_o;
  logic err;
  int miscompares = 0, checks = 0, e;
  always #5 clk = ~clk;
  sms_field_model FM (.red_on_i(red), .ctl_on_i(ctl), .line_vac_i(line), .red_rms_o(rr),
    .red_enable_rms_o(ren), .preempt_one_rms_o(p1), .preempt_two_rms_o(p2), .line_rms_o(lr));
  sms_status_logic #(.FLASH2_HALF(4), .FLASH4_HALF(2), .BLINK_PERIOD(20), .BLINK_ON(5),
    .SAMPLE(8)) DUT (
    .core_clk_i(clk), .sys_rst_i(rst), .red_rms_i(rr), .red_enable_rms_i(ren),
    .preempt_one_rms_i(p1), .preempt_two_rms_i(p2), .line_rms_i(lr), .yellow_on_i(yel),
    .green_on_i(grn), .min_flash_i(mf), .red_fail_detect_i(rfd), .dc_fault_i(flt[0]),
    .ctl_wd_fault_i(flt[1]), .conflict_fault_i(flt[2]), .int_wd_fault_i(flt[3]),
    .mem_fault_i(flt[4]), .psu_fault_i(flt[5]), .external_flash_input_i(xf),
    .reset_button_i(btn), .ext_reset_i(xr), .red_cable_present_i(cab), .config_i(cfg),
    .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .lamps_o(lamps_o), .red_led_o(rl), .yellow_led_o(yl), .green_led_o(gl),
    .red_fail_mon_en_o(mon[0]), .dual_mon_en_o(mon[1]), .seq_mon_en_o(mon[2]));
  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // reference crc: shift in each configuration bit, msb first
  function automatic logic [15:0] crc16(input sms_cfg_s c);
    logic [15:0]      r;
    logic [CFG_W-1:0] b;
    r = CRC_INIT;
    b = c;
    for (int k = CFG_W - 1; k >= 0; k--) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ b[k]) ? CRC_POLY : 16'h0000);
    end
    return r;
  endfunction
  // apb master, entered just after an edge; waits for pready under a bound
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin @(posedge clk); n++; end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin miscompares++; results(); end
    rd = prdata_o; err = pslverr_o;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  // counts lit cycles and toggles of one lamp; toggles tell the rates apart
  task automatic lit(input int b, input int n, input int exp, input int tog);
    int c, t;
    logic p;
    c = 0;
    t = 0;
    p = lamps_o[b];
    repeat (n) begin
      @(posedge clk);
      c += lamps_o[b];
      t += lamps_o[b] ^ p;
      p = lamps_o[b];
    end
    chk(c, exp);
    chk(t, tog);
  endtask
  initial begin
    void'($urandom(49));
    cfg = '0;
    cfg.watchdog[0] = 1;
    cfg.permissive = 120'({4{$urandom}});
    repeat (3) @(posedge clk);
    rst <= 0;
    apb(CTRL_OFS, 0, 0); chk(rd, CTRL_RST);
    apb(CTRL_OFS, 1, 32'hffff_6055); apb(CTRL_OFS, 0, 0); chk(rd, 32'h0000_6055);
    apb(8'h40, 1, 32'h1); chk(err, 1);
    // qualification and gating; last pass pulls the red cable
    for (int i = 0; i < 8; i++) begin
      red <= $urandom; yel <= $urandom; grn <= $urandom; ctl <= $urandom;
      inv <= $urandom; xf <= $urandom; cab <= (i != 7);
      @(posedge clk);
      cfg.options[0] <= inv;
      repeat (8) @(posedge clk);
      e = ctl[0] & ~(ctl[1] ^ inv) & ~ctl[2] & cab;
      mx = {ctl[0] & cab & ~xf, ctl[0] & cab, e[0]};
      chk(mon, mx);
      chk(rl, red & {16{cab}});
      chk({yl, gl}, {yel, grn});
      apb(STATUS_OFS, 0, 0);
      chk(rd[27:0], {5'h00, cab, mx, ctl[2], ctl[1] ^ inv, ctl[0], red});
    end
    ctl <= 3'b001; xf <= 0; repeat (8) @(posedge clk);
    // each fault source lights its lamp, latches, and a reset clears it;
    // the red cable is still out, so this is plain conflict monitoring
    for (int k = 0; k < 6; k++) begin
      flt[k] <= 1; repeat (3) @(posedge clk); flt[k] <= 0; repeat (6) @(posedge clk);
      e = k < 3 ? 4 - k : 1;
      chk(lamps_o[e], 1);
      chk(lamps_o[4:1] & ~(4'h1 << (e - 1)), 0);
      // front button and external reset take turns
      {xr, btn} <= k[0] ? 2'b10 : 2'b01; repeat (4) @(posedge clk);
      {xr, btn} <= 2'b00; repeat (6) @(posedge clk);
      chk(lamps_o[e], 0);
      apb(COUNTS_OFS, 0, 0); chk(rd[31:16], k + 1);
    end
    // red-fail detection is ignored under preemption, latched otherwise
    cab <= 1; cfg.options[0] <= 0; ctl <= 3'b011; repeat (10) @(posedge clk);
    rfd <= 1; repeat (3) @(posedge clk); rfd <= 0; repeat (4) @(posedge clk);
    apb(STATUS_OFS, 0, 0); chk(rd[27:23], 0);
    ctl <= 3'b001; repeat (10) @(posedge clk);
    rfd <= 1; repeat (3) @(posedge clk); rfd <= 0; repeat (4) @(posedge clk);
    chk(lamps_o[0], 1);
    // history frozen by the fault; newest entry holds the steady inputs
    apb(SEQLO_OFS, 0, 0); chk(rd, {yel, red});
    apb(SEQHI_OFS, 0, 0); chk(rd, {13'h0, 3'b001, grn});
    // clearing a fault logs once; a reset with nothing latched does not
    repeat (2) begin
      btn <= 1; repeat (4) @(posedge clk); btn <= 0; repeat (6) @(posedge clk);
    end
    apb(COUNTS_OFS, 0, 0); chk(rd[31:16], 7);
    lit(5, 32, 32, 0);
    line <= 8'h58; repeat (6) @(posedge clk); lit(5, 32, 16, 8);
    line <= 8'h78; mf <= 1; repeat (6) @(posedge clk); lit(5, 32, 16, 16);
    line <= 8'h4f; mf <= 0; repeat (6) @(posedge clk); lit(5, 8, 0, 0);
    lit(3, 40, 10, 4);
    line <= 8'h78; ctl <= 3'b000; repeat (6) @(posedge clk); lit(0, 40, 10, 4);
    apb(COUNTS_OFS, 0, 0); e = rd[15:0];
    // watchdog switch off: lamp blinks and exactly one config entry is logged
    cfg.watchdog[0] <= 0; repeat (12) @(posedge clk); lit(3, 40, 10, 4);
    apb(CFGLOG_OFS, 0, 0); chk(rd, {11'h000, 5'h01, crc16(cfg)});
    apb(COUNTS_OFS, 0, 0); chk(rd[15:0], e + 1);
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule

/* File: sim/sms_field_model.sv */
`timescale 1ns/100ps
// cabinet side: turns on/off intents into rms levels just past each threshold,
// so the qualifier is exercised at its margins rather than at comfortable levels
module sms_field_model (
  input  wire logic [15:0]             red_on_i,
  input  wire logic [2:0]              ctl_on_i,
  input  wire logic [7:0]              line_vac_i,
  output sms_pkg::sms_rms_t [15:0]     red_rms_o,
  output sms_pkg::sms_rms_t            red_enable_rms_o,
  output sms_pkg::sms_rms_t            preempt_one_rms_o,
  output sms_pkg::sms_rms_t            preempt_two_rms_o,
  output sms_pkg::sms_rms_t            line_rms_o
);
  import sms_pkg::*;
  localparam sms_rms_t ON_V  = 8'h47; // 71, one above active
  localparam sms_rms_t OFF_V = 8'h31; // 49, one below inactive
  // field outputs, red channels then enable and both preempts
  always_comb begin
    for (int k = 0; k < 16; k++) red_rms_o[k] = red_on_i[k] ? ON_V : OFF_V;
    red_enable_rms_o  = ctl_on_i[0] ? ON_V : OFF_V;
    preempt_one_rms_o = ctl_on_i[1] ? ON_V : OFF_V;
    preempt_two_rms_o = ctl_on_i[2] ? ON_V : OFF_V;
  end
  assign line_rms_o = line_vac_i;
endmodule
